// ---- logic/tbf_pkg.sv ----
// shared constants, types and register map of the trace buffer line formatter
package tbf_pkg;
	// ****************************************
	// buffer geometry
	// ****************************************
	localparam int TBF_LINES = 64;
	localparam int TBF_PTR_W = 6;
	localparam int TBF_CNT_W = 7;
	localparam logic [6:0] TBF_CNT_FULL = 7'h40;
	localparam logic [6:0] TBF_CNT_RST = 7'h00;
	localparam logic [5:0] TBF_PTR_RST = 6'h00;
	localparam logic [5:0] TBF_PTR_LAST = 6'h3F;
	localparam int TBF_OFS_W = 6;

	// ****************************************
	// register map (byte offsets) and fields
	// ****************************************
	localparam logic [3:0] TBF_ADDR_CTRL = 4'h0;
	localparam logic [3:0] TBF_ADDR_COUNT = 4'h4;
	localparam logic [3:0] TBF_ADDR_TRACE = 4'h8;
	localparam logic [3:0] TBF_ADDR_STAT = 4'hC;
	localparam int TBF_CTRL_MODE_LSB = 0;
	localparam int TBF_CTRL_CLEAR_BIT = 2;
	localparam int TBF_STAT_WRAP_BIT = 2;
	localparam logic [15:0] TBF_RDATA_RST = 16'h0000;

	// ****************************************
	// trace modes and line encodings
	// ****************************************
	typedef enum logic [1:0] {
		TBF_MODE_NORMAL = 2'h0,
		TBF_MODE_LOOP = 2'h1,
		TBF_MODE_DETAIL = 2'h2,
		TBF_MODE_COMP = 2'h3
	} tbf_mode_t;
	localparam tbf_mode_t TBF_MODE_RST = TBF_MODE_NORMAL;

	localparam logic [1:0] TBF_FMT_BASE = 2'h0;
	localparam logic [1:0] TBF_FMT_ONE = 2'h1;
	localparam logic [1:0] TBF_FMT_TWO = 2'h2;
	localparam logic [1:0] TBF_FMT_THREE = 2'h3;
	localparam logic TBF_SZ_WORD = 1'b0;
	localparam logic TBF_SZ_BYTE = 1'b1;
	localparam logic TBF_RW_WRITE = 1'b0;
	localparam logic TBF_RW_READ = 1'b1;
	localparam logic TBF_SD_SOURCE = 1'b0;
	localparam logic TBF_SD_DEST = 1'b1;
	localparam logic [3:0] TBF_DATA_TOP = 4'h0;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic valid;
		logic [17:0] pc;
		logic dest;
		logic vector;
	} tbf_cof_t;

	typedef struct packed {
		logic valid;
		logic [17:0] addr;
		logic byte_acc;
		logic read;
		logic [7:0] lo_addr_byte;
		logic [7:0] hi_addr_byte;
	} tbf_acc_t;

	typedef struct packed {
		logic valid;
		logic [17:0] pc;
	} tbf_op_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tbf_bus_t;
endpackage

// ---- logic/tbf_formatter.sv ----
// trace buffer line formatter: capture formatting, line store and host read port
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - normal/loop lines: 4-bit top, two bytes
// - detail entry is address line then data line
// - detail adds two to valid line counter
// - byte access: low data byte, high cleared
// - word: lower-address byte into byte1
// - detail top: size, rw, address 17:16
// - size flag 0 word, 1 byte
// - rw flag 0 write, 1 read
// - top bit3 source/dest, bits1:0 pc 17:16
// - top bit2 set for vector addresses
// - vector entries always flagged destination
// - compressed line: 2-bit format, three offsets
// - format 00 holds full base pc
// - format counts offsets held in line
// - new base when pc 17:6 changes
// - offsets relative to aligned 64-address block
// - buffer line zero always a base line
// - host reads low word, then top field
module tbf_formatter import tbf_pkg::*; (
	input wire logic clock,
	input wire logic resetn,
	input wire logic clk_en,
	input wire tbf_bus_t bus,
	output logic [15:0] rd_data,
	input wire tbf_cof_t cof,
	input wire tbf_acc_t acc,
	input wire tbf_op_t op,
	output logic cap_ready
);
	// ****************************************
	// reset release
	// ****************************************
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [1:0] {
		TBF_ST_ADDR = 2'b01,
		TBF_ST_DATA = 2'b10
	} tbf_state_t;

	logic [19:0] mem [TBF_LINES];
	tbf_state_t st_q, st_d;
	tbf_mode_t mode_q;
	logic [5:0] wr_ptr_q, wr_ptr_d;
	logic [6:0] cnt_q, cnt_d;
	logic wrapped_q;
	logic [19:0] pend_q;
	logic [11:0] base_q;
	logic base_ok_q;
	logic [1:0] slot_q, slot_d;
	logic [17:0] offs_q, offs_d;
	logic [17:0] last_q;
	logic last_ok_q;
	logic [5:0] rd_ptr_q;
	logic half_q;
	logic [15:0] rd_data_q;
	logic cap_ready_q;

	// count saturates at a full buffer; reads never lower it
	function automatic logic [6:0] sat_add(input logic [6:0] c, input logic [6:0] n);
		logic [7:0] s;
		s = {1'b0, c} + {1'b0, n};
		sat_add = (s > {1'b0, TBF_CNT_FULL}) ? TBF_CNT_FULL : s[6:0];
	endfunction

	// ****************************************
	// register decode
	// ****************************************
	wire ctrl_wr = bus.wr && bus.addr == TBF_ADDR_CTRL;
	wire clear = ctrl_wr && bus.wdata[TBF_CTRL_CLEAR_BIT];
	wire trace_wr = bus.wr && bus.addr == TBF_ADDR_TRACE;
	wire trace_rd = bus.rd && bus.addr == TBF_ADDR_TRACE;

	// ****************************************
	// capture qualification
	// ****************************************
	wire is_cof_mode = mode_q == TBF_MODE_NORMAL || mode_q == TBF_MODE_LOOP;
	// loop filter only drops repeated sources; repeated destinations hint at a bug
	wire loop_dup = mode_q == TBF_MODE_LOOP && !cof.dest && !cof.vector && last_ok_q
		&& cof.pc == last_q;
	// a clear write in the same cycle wins over any capture
	wire cof_take = cof.valid && is_cof_mode && !loop_dup && !clear;
	wire acc_take = acc.valid && mode_q == TBF_MODE_DETAIL && st_q == TBF_ST_ADDR && !clear;
	wire op_take = op.valid && mode_q == TBF_MODE_COMP && !clear;

	// ****************************************
	// line builders
	// ****************************************
	wire sd_bit = (cof.dest || cof.vector) ? TBF_SD_DEST : TBF_SD_SOURCE;
	wire [19:0] cof_line = {sd_bit, cof.vector, cof.pc};
	wire sz_bit = acc.byte_acc ? TBF_SZ_BYTE : TBF_SZ_WORD;
	wire rw_bit = acc.read ? TBF_RW_READ : TBF_RW_WRITE;
	wire [19:0] addr_line = {sz_bit, rw_bit, acc.addr};
	// byte: low byte only; word: lower address into byte1
	wire [15:0] data_word = acc.byte_acc ? {8'h00, acc.lo_addr_byte}
		: {acc.lo_addr_byte, acc.hi_addr_byte};
	wire [19:0] data_line = {TBF_DATA_TOP, data_word};

	// compressed format
	// after a wrap the line at zero must open with a full base
	wire fresh_zero = slot_q == 2'h0 && wr_ptr_q == TBF_PTR_RST;
	wire new_base = !base_ok_q || op.pc[17:6] != base_q || fresh_zero;
	wire [5:0] base_at = (slot_q != 2'h0) ? wr_ptr_q + 6'h01 : wr_ptr_q;
	wire [19:0] base_line = {TBF_FMT_BASE, op.pc};
	// offset is the low six bits: distance from the block's lowest address
	wire [17:0] ofs_shift = {12'h000, op.pc[5:0]} << (TBF_OFS_W * slot_q);
	wire [17:0] ofs_new = offs_q | ofs_shift;
	wire [1:0] ofs_fmt = slot_q + 2'h1;
	wire [19:0] ofs_line = {ofs_fmt, ofs_new};

	// ****************************************
	// write selection
	// ****************************************
	logic wr_en;
	logic [5:0] wr_addr;
	logic [19:0] wr_line;
	always_comb begin
		wr_en = 1'b0;
		wr_addr = wr_ptr_q;
		wr_line = 20'h0_0000;
		st_d = st_q;
		wr_ptr_d = wr_ptr_q;
		cnt_d = cnt_q;
		slot_d = slot_q;
		offs_d = offs_q;
		if (clear) begin
			st_d = TBF_ST_ADDR;
			wr_ptr_d = TBF_PTR_RST;
			cnt_d = TBF_CNT_RST;
			slot_d = 2'h0;
			offs_d = 18'h0_0000;
		end else begin
			unique case (st_q)
				TBF_ST_ADDR: begin
					if (acc_take) begin
						wr_en = 1'b1;
						wr_line = addr_line;
						wr_ptr_d = wr_ptr_q + 6'h01;
						cnt_d = sat_add(cnt_q, 7'h02);
						st_d = TBF_ST_DATA;
					end
				end
				TBF_ST_DATA: begin
					wr_en = 1'b1;
					wr_line = pend_q;
					wr_ptr_d = wr_ptr_q + 6'h01;
					st_d = TBF_ST_ADDR;
				end
				default: st_d = TBF_ST_ADDR;
			endcase
			if (cof_take) begin
				wr_en = 1'b1;
				wr_line = cof_line;
				wr_ptr_d = wr_ptr_q + 6'h01;
				cnt_d = sat_add(cnt_q, 7'h01);
			end else if (op_take && new_base) begin
				wr_en = 1'b1;
				wr_addr = base_at;
				wr_line = base_line;
				wr_ptr_d = base_at + 6'h01;
				cnt_d = sat_add(cnt_q, 7'h01);
				slot_d = 2'h0;
				offs_d = 18'h0_0000;
			end else if (op_take) begin
				// partial line is rewritten in place so a read always sees it
				wr_en = 1'b1;
				wr_line = ofs_line;
				cnt_d = (slot_q == 2'h0) ? sat_add(cnt_q, 7'h01) : cnt_q;
				if (slot_q == 2'h2) begin
					wr_ptr_d = wr_ptr_q + 6'h01;
					slot_d = 2'h0;
					offs_d = 18'h0_0000;
				end else begin
					slot_d = slot_q + 2'h1;
					offs_d = ofs_new;
				end
			end
		end
	end

	// ****************************************
	// line store
	// ****************************************
	always_ff @(posedge clock) begin
		if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_line;
		end
	end

	// ****************************************
	// capture state
	// ****************************************
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= TBF_ST_ADDR;
			wr_ptr_q <= TBF_PTR_RST;
			cnt_q <= TBF_CNT_RST;
			slot_q <= 2'h0;
			offs_q <= 18'h0_0000;
			cap_ready_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			wr_ptr_q <= wr_ptr_d;
			cnt_q <= cnt_d;
			slot_q <= slot_d;
			offs_q <= offs_d;
			cap_ready_q <= st_d == TBF_ST_ADDR;
		end
	end

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wrapped_q <= 1'b0;
			pend_q <= 20'h0_0000;
			base_q <= 12'h000;
			base_ok_q <= 1'b0;
			last_q <= 18'h0_0000;
			last_ok_q <= 1'b0;
		end else if (clk_en) begin
			wrapped_q <= !clear && (wrapped_q || (wr_en && wr_ptr_d < wr_ptr_q));
			if (acc_take) begin
				pend_q <= data_line;
			end
			if (clear) begin
				base_ok_q <= 1'b0;
			end else if (op_take && new_base) begin
				base_q <= op.pc[17:6];
				base_ok_q <= 1'b1;
			end
			if (clear) begin
				last_ok_q <= 1'b0;
			end else if (cof_take) begin
				last_q <= cof.pc;
				last_ok_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// host read port
	// ****************************************
	wire [19:0] rd_line = mem[rd_ptr_q];
	wire [15:0] trace_word = half_q ? {12'h000, rd_line[19:16]} : rd_line[15:0];
	wire [15:0] stat_word = {13'h0000, wrapped_q, slot_q};
	logic [15:0] rd_mux;
	always_comb begin
		unique case (bus.addr)
			TBF_ADDR_CTRL: rd_mux = {14'h0000, mode_q};
			TBF_ADDR_COUNT: rd_mux = {9'h000, cnt_q};
			TBF_ADDR_TRACE: rd_mux = trace_word;
			TBF_ADDR_STAT: rd_mux = stat_word;
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= TBF_MODE_RST;
			rd_ptr_q <= TBF_PTR_RST;
			half_q <= 1'b0;
			rd_data_q <= TBF_RDATA_RST;
		end else if (clk_en) begin
			if (ctrl_wr) begin
				mode_q <= tbf_mode_t'(bus.wdata[TBF_CTRL_MODE_LSB +: 2]);
			end
			// restart from the oldest line
			if (trace_wr || clear) begin
				rd_ptr_q <= (wrapped_q && !clear) ? wr_ptr_q : TBF_PTR_RST;
				half_q <= 1'b0;
			end else if (trace_rd) begin
				half_q <= !half_q;
				rd_ptr_q <= half_q ? rd_ptr_q + 6'h01 : rd_ptr_q;
			end
			// data only in the cycle after the strobe, zero otherwise
			rd_data_q <= bus.rd ? rd_mux : TBF_RDATA_RST;
		end
	end

	assign rd_data = rd_data_q;
	assign cap_ready = cap_ready_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n_q);

	sequence s_detail_entry;
		clk_en && acc_take && !acc.byte_acc ##1 clk_en && wr_en;
	endsequence

	chk_detail_data_line: assert property (s_detail_entry |-> wr_line[19:16] == 4'h0)
		else $error("detail data line top field not zero");
	chk_detail_count_two: assert property (clk_en && acc_take && cnt_q < 7'h3E
		|=> cnt_q == $past(cnt_q) + 7'h02)
		else $error("detail entry did not add two lines");
	chk_word_byte_order: assert property (s_detail_entry
		|-> wr_line[15:8] == $past(acc.lo_addr_byte))
		else $error("word access byte order wrong");
	chk_byte_high_clear: assert property (clk_en && acc_take && acc.byte_acc
		##1 clk_en && !clear |-> wr_line[15:8] == 8'h00 && wr_line[7:0] == $past(acc.lo_addr_byte))
		else $error("byte access high byte not cleared");
	chk_ready_after_data: assert property (clk_en && st_q == TBF_ST_DATA
		|=> cap_ready_q)
		else $error("capture not ready after data line");
	chk_detail_top_field: assert property (clk_en && acc_take
		|-> wr_line[19] == acc.byte_acc && wr_line[18] == acc.read)
		else $error("detail info bits wrong");
	chk_vector_is_dest: assert property (clk_en && cof_take && cof.vector
		|=> mem[$past(wr_addr)][19:18] == 2'b11)
		else $error("vector entry not flagged destination");
	chk_cof_pc_stored: assert property (clk_en && cof_take
		|=> mem[$past(wr_addr)][17:0] == $past(cof.pc))
		else $error("change of flow pc not stored");
	chk_zero_line_base: assert property (clk_en && wr_en && mode_q == TBF_MODE_COMP
		&& wr_addr == TBF_PTR_RST |-> wr_line[19:18] == TBF_FMT_BASE)
		else $error("line zero is not a base line");
	chk_base_on_change: assert property (clk_en && op_take && base_ok_q
		&& op.pc[17:6] != base_q |-> wr_line[19:18] == TBF_FMT_BASE)
		else $error("block change without new base");
	chk_offset_fmt: assert property (clk_en && op_take && !new_base
		|-> wr_line[19:18] == slot_q + 2'h1 && wr_line[17:12] == (slot_q == 2'h2
		? op.pc[5:0] : 6'h00))
		else $error("incremental line format wrong");
	chk_read_top_word: assert property (bus.rd && bus.addr == TBF_ADDR_TRACE && half_q
		&& !bus.wr && clk_en |=> rd_data_q[15:4] == 12'h000)
		else $error("top field word has upper bits set");
endmodule

// ---- sim/tbf_core_model.sv ----
// stand-in for the traced core: change-of-flow, detail access and opcode entries
`timescale 1ns/10ps
module tbf_core_model import tbf_pkg::*; (
	input wire logic clock,
	input wire logic cap_ready,
	output tbf_cof_t cof,
	output tbf_acc_t acc,
	output tbf_op_t op
);
	// ****************************************
	// entry drivers
	// ****************************************
	initial begin
		cof = '0;
		acc = '0;
		op = '0;
	end

	task automatic put_cof(input logic [17:0] pc, input logic d, input logic v);
		cof <= '{1'b1, pc, d, v};
		@(posedge clock);
	endtask

	task automatic put_op(input logic [17:0] pc);
		op <= '{1'b1, pc};
		@(posedge clock);
	endtask

	// released lines show the inverse, never a stale copy
	task automatic quiet();
		cof <= '{1'b0, ~cof.pc, ~cof.dest, ~cof.vector};
		op <= '{1'b0, ~op.pc};
		@(posedge clock);
	endtask

	// a refused access is held until taken or for at most 8 cycles, then one idle cycle for spacing
	task automatic put_acc(input logic [17:0] a, input logic b, input logic r,
		input logic [7:0] lo, input logic [7:0] hi);
		int n;
		acc <= '{1'b1, a, b, r, lo, hi};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (cap_ready !== 1'b1 && n < 8);
		acc <= ~acc;
		@(posedge clock);
	endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the trace buffer line formatter
`timescale 1ns/10ps
module tb import tbf_pkg::*; ;
	logic clock;
	logic resetn;
	logic clk_en;
	tbf_bus_t bus;
	logic [15:0] rd_data;
	tbf_cof_t cof;
	tbf_acc_t acc;
	tbf_op_t op;
	logic cap_ready;
	logic rd_was;
	logic [15:0] exp_q[$];
	logic [19:0] lines[$];
	int n_mismatch;
	int samples_checked;
	int cyc;
	logic [17:0] p;
	logic [17:0] q;
	logic [5:0] o[4];
	logic [7:0] lo;
	logic [7:0] hi;

	tbf_formatter i_tbf_formatter(.clock(clock), .resetn(resetn), .clk_en(clk_en), .bus(bus),
		.rd_data(rd_data), .cof(cof), .acc(acc), .op(op), .cap_ready(cap_ready));
	tbf_core_model i_tbf_core_model(.clock(clock), .cap_ready(cap_ready), .cof(cof),
		.acc(acc), .op(op));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ****************************************
	// checking and host bus tasks
	// ****************************************
	task automatic end_of_test();
		if (exp_q.size() != 0) begin
			n_mismatch++;
		end
		$display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic bus_op(input logic [3:0] a, input logic [15:0] d, input logic w);
		bus <= '{a, d, w, ~w};
		@(posedge clock);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		exp_q.push_back(exp);
		bus_op(a, 16'h0000, 1'b0);
	endtask

	task automatic idle();
		bus <= '0;
		@(posedge clock);
	endtask

	task automatic start(input tbf_mode_t m);
		bus_op(TBF_ADDR_CTRL, 16'h0004 | 16'(m), 1'b1);
		idle();
	endtask

	// rewind, then drain every expected line low word first
	task automatic read_lines();
		rd(TBF_ADDR_COUNT, 16'(lines.size()));
		bus_op(TBF_ADDR_TRACE, 16'h0000, 1'b1);
		foreach (lines[i]) begin
			rd(TBF_ADDR_TRACE, lines[i][15:0]);
			rd(TBF_ADDR_TRACE, {12'h000, lines[i][19:16]});
		end
		idle();
		lines.delete();
	endtask

	// ****************************************
	// read data monitor and timeout
	// ****************************************
	always @(posedge clock) begin
		if (rd_was === 1'b1) begin
			chk(rd_data, exp_q.pop_front());
		end else if (resetn === 1'b1) begin
			chk(rd_data, 16'h0000);
		end
		rd_was <= bus.rd;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		bus = '0;
		rd_was = 1'b0;
		n_mismatch = 0;
		samples_checked = 0;
		cyc = 0;
		void'($urandom(82741));
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		rd(4'h2, 16'h0000);
		// normal keeps a repeated source, loop drops it
		for (int m = 0; m < 2; m++) begin
			p = 18'($urandom);
			q = 18'($urandom);
			start(tbf_mode_t'(m));
			i_tbf_core_model.put_cof(p, 1'b0, 1'b0);
			i_tbf_core_model.put_cof(p, 1'b0, 1'b0);
			i_tbf_core_model.put_cof(q, 1'b1, 1'b0);
			i_tbf_core_model.put_cof(q, 1'b0, 1'b1);
			i_tbf_core_model.quiet();
			lines.push_back({2'b00, p});
			if (m == 0) lines.push_back({2'b00, p});
			lines.push_back({2'b10, q});
			lines.push_back({2'b11, q});
			read_lines();
		end
		// detail: every size and direction
		start(TBF_MODE_DETAIL);
		for (int i = 0; i < 4; i++) begin
			p = 18'($urandom);
			lo = 8'($urandom);
			hi = 8'($urandom);
			i_tbf_core_model.put_acc(p, i[0], i[1], lo, hi);
			lines.push_back({i[0], i[1], p});
			lines.push_back({4'h0, i[0] ? {8'h00, lo} : {lo, hi}});
		end
		@(negedge clock);
		chk(16'(cap_ready), 16'h0001);
		@(posedge clock);
		read_lines();
		// compressed: base, full line, partial line, new base
		start(TBF_MODE_COMP);
		p = 18'($urandom);
		foreach (o[i]) o[i] = 6'($urandom);
		i_tbf_core_model.put_op(p);
		foreach (o[i]) i_tbf_core_model.put_op({p[17:6], o[i]});
		i_tbf_core_model.quiet();
		rd(TBF_ADDR_STAT, 16'h0001);
		idle();
		q = p ^ 18'h0_1000;
		i_tbf_core_model.put_op(q);
		i_tbf_core_model.quiet();
		// a frozen clock enable must drop this out-of-block opcode
		clk_en <= 1'b0;
		i_tbf_core_model.put_op(p);
		i_tbf_core_model.quiet();
		clk_en <= 1'b1;
		lines.push_back({2'b00, p});
		lines.push_back({2'b11, o[2], o[1], o[0]});
		lines.push_back({2'b01, 12'h000, o[3]});
		lines.push_back({2'b00, q});
		read_lines();
		// compressed wrap: the line that lands on zero must be a base again
		start(TBF_MODE_COMP);
		for (int k = 0; k < 63; k++) begin
			p = {k[11:0], 6'($urandom)};
			i_tbf_core_model.put_op(p);
			if (k > 0) lines.push_back({2'b00, p});
		end
		foreach (o[i]) o[i] = 6'($urandom);
		foreach (o[i]) i_tbf_core_model.put_op({p[17:6], o[i]});
		i_tbf_core_model.quiet();
		rd(TBF_ADDR_STAT, 16'h0004);
		idle();
		lines.push_back({2'b11, o[2], o[1], o[0]});
		lines.push_back({2'b00, p[17:6], o[3]});
		read_lines();
		repeat (2) @(posedge clock);
		end_of_test();
	end
endmodule
